//--- hw/energy_detect_pkg.sv
// package for the energy detect power control block: register map, field layout,
// reset values, sequencer states and timing constants.
// assumes a 100 MHz hclk and a word-aligned AHB-Lite register window.
package energy_detect_pkg;

    // register indices; the byte address is four times the index
    localparam int          IDX_W             = 8;
    localparam int          IDX_LSB           = 2;
    localparam logic [7:0]  CTRL_IDX          = 8'h1d;
    localparam logic [7:0]  IRQ_STATUS_IDX    = 8'h20;
    localparam logic [7:0]  IRQ_MASK_IDX      = 8'h21;
    localparam logic [7:0]  SOFT_CTRL_IDX     = 8'h22;

    // energy_detect_control fields
    localparam int          CTRL_W            = 16;
    localparam int          ENABLE_BIT        = 15;
    localparam int          AUTO_UP_BIT       = 14;
    localparam int          AUTO_DOWN_BIT     = 13;
    localparam int          MANUAL_BIT        = 12;
    localparam int          BURST_DIS_BIT     = 11;
    localparam int          PWR_STATE_BIT     = 10;
    localparam int          ERR_MET_BIT       = 9;
    localparam int          DATA_MET_BIT      = 8;
    localparam int          ERR_THR_LSB       = 4;
    localparam int          DATA_THR_LSB      = 0;
    localparam int          THR_W             = 4;
    localparam logic        AUTO_UP_RST       = 1'b1;
    localparam logic        AUTO_DOWN_RST     = 1'b1;
    localparam logic        BURST_DIS_RST     = 1'b0;
    localparam logic [3:0]  THR_RST           = 4'h1;

    // soft control register
    localparam int          SOFT_RESET_BIT    = 9;

    // interrupt status and mask layout
    localparam int          IRQ_W             = 3;
    localparam int          IRQ_DATA_BIT      = 0;
    localparam int          IRQ_ERR_BIT       = 1;
    localparam int          IRQ_PWR_BIT       = 2;

    // timing
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          IDLE_TIME_S       = 2;
    localparam int          NS_PER_S          = 1000000000;
    localparam int          IDLE_CYCLES       = IDLE_TIME_S * (NS_PER_S / CLK_PERIOD_NS);
    localparam int          IDLE_W            = 28;
    localparam int          PULSE_GAP_NS      = 1000;
    localparam int          PULSE_GAP_CYCLES  = (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          GAP_W             = 16;
    localparam int          BURST_PULSES      = 4;
    localparam int          SINGLE_PULSES     = 1;
    localparam int          PULSE_CNT_W       = 3;

    typedef enum logic [1:0] {
        SEQ_DOWN,
        SEQ_BURST,
        SEQ_UP
    } seq_state_t;

endpackage

//--- hw/threshold_if.sv
// interface joining the control block to one event threshold counter.
// assumes both ends run on hclk.
interface threshold_if #(
    parameter int THR_W = 4
);
    logic             event_p;
    logic             clear;
    logic [THR_W-1:0] threshold;
    logic             met_p;
    logic             reached;

    modport owner   (output event_p, output clear, output threshold,
                     input met_p, input reached);
    modport counter (input event_p, input clear, input threshold,
                     output met_p, output reached);
endinterface

//--- hw/threshold_counter.sv
// saturating event counter compared against a programmable threshold.
// assumes event and clear are one-cycle pulses on hclk.
module threshold_counter #(
    parameter int THR_W = 4
) (
    input  wire logic      hclk,
    input  wire logic      hresetn,
    threshold_if.counter   thr
);
    logic [THR_W-1:0] count_ff;
    logic [THR_W-1:0] nxt_count;
    logic             met_ff;

    // saturate so a burst of noise cannot wrap back below the threshold
    always_comb begin
        nxt_count = count_ff;
        if (thr.event_p && (count_ff != {THR_W{1'b1}})) begin
            nxt_count = count_ff + {{(THR_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff <= '0;
        end else if (thr.clear) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            met_ff <= 1'b0;
        end else begin
            met_ff <= thr.event_p && !thr.clear && (nxt_count >= thr.threshold);
        end
    end

    assign thr.met_p   = met_ff;
    assign thr.reached = (count_ff >= thr.threshold) && (count_ff != '0);
endmodule

//--- hw/energy_detect_power_control.sv
// energy detect power control for one transceiver port, with its AHB-Lite register slave.
// assumes line event inputs are synchronous one-cycle pulses and line_energy is a level.
//
// Behaviour
// - energy detect runs only while the enable bit 15 is set, whose reset value is the strap.
// - with auto power-up bit 14 set, power-up starts once data events reach the data threshold.
// - with auto power-down bit 13 set, power-down starts when the line carries no energy.
// - writing 1 to self-clearing bit 12 toggles the power state regardless of thresholds.
// - with burst disable bit 11 clear, four data pulses go out at each power-up.
// - with burst disable bit 11 set, exactly one data pulse goes out at each power-up.
// - read-only bit 10 shows 1 when powered up and 0 when powered down.
// - bit 9 flags the error threshold met, clears on read, and triggers no power change, only interrupt status bit 1.
// - bit 8 flags data events at or above the data threshold and clears on read.
// - bits 7:4, reset 0001, hold the error event threshold.
// - bits 3:0, reset 0001, hold the data event threshold.
// - both event counters reset after about 2 seconds with no data event.
// - the self-clearing soft reset resets the sequencer, event counters, quiet timer and bits 9:8; other registers keep their values.
module energy_detect_power_control
    import energy_detect_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES,
    parameter int PULSE_GAP  = PULSE_GAP_CYCLES,
    parameter int BURST_LEN  = BURST_PULSES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        enable_strap,
    input  wire logic        line_energy,
    input  wire logic        data_event,
    input  wire logic        error_event,
    output logic             detect_powered,
    output logic             detect_pulse,
    output logic             irq
);

    threshold_if #(.THR_W(THR_W)) err_if ();
    threshold_if #(.THR_W(THR_W)) data_if ();

    logic                   enable_ff;
    logic                   strap_taken_ff;
    logic                   auto_up_ff;
    logic                   auto_down_ff;
    logic                   burst_dis_ff;
    logic [THR_W-1:0]       err_thr_ff;
    logic [THR_W-1:0]       data_thr_ff;
    logic                   manual_ff;
    logic                   soft_reset_ff;
    logic                   err_met_ff;
    logic                   data_met_ff;
    logic [IRQ_W-1:0]       irq_status_ff;
    logic [IRQ_W-1:0]       irq_mask_ff;
    logic                   irq_ff;
    seq_state_t             state_ff;
    logic                   pwr_state_ff;
    logic [PULSE_CNT_W-1:0] pulses_left_ff;
    logic [GAP_W-1:0]       gap_ff;
    logic                   pulse_ff;
    logic [IDLE_W-1:0]      idle_ff;
    logic                   idle_clear;
    logic                   pwr_change;
    logic                   go_up;
    logic                   go_down;
    logic                   wr_pend_ff;
    logic                   rd_pend_ff;
    logic [IDX_W-1:0]       idx_ff;
    logic                   hreadyout_ff;
    logic [31:0]            hrdata_ff;
    logic                   addr_take;
    logic                   wr_apply;
    logic                   rd_apply;
    logic [CTRL_W-1:0]      ctrl_view;
    logic [31:0]            rd_value;

    // bus side
    assign addr_take = hsel && htrans[1] && hready;
    assign wr_apply  = wr_pend_ff;
    assign rd_apply  = rd_pend_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            idx_ff     <= '0;
        end else begin
            wr_pend_ff <= addr_take && hwrite;
            rd_pend_ff <= addr_take && !hwrite;
            if (addr_take) begin
                idx_ff <= haddr[IDX_LSB +: IDX_W];
            end
        end
    end

    // reads take one wait state so a write just before is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= '0;
        end else begin
            hreadyout_ff <= !(addr_take && !hwrite);
            if (rd_apply) begin
                hrdata_ff <= rd_value;
            end
        end
    end

    always_comb begin
        ctrl_view                               = '0;
        ctrl_view[ENABLE_BIT]                   = enable_ff;
        ctrl_view[AUTO_UP_BIT]                  = auto_up_ff;
        ctrl_view[AUTO_DOWN_BIT]                = auto_down_ff;
        ctrl_view[BURST_DIS_BIT]                = burst_dis_ff;
        ctrl_view[PWR_STATE_BIT]                = pwr_state_ff;
        ctrl_view[ERR_MET_BIT]                  = err_met_ff;
        ctrl_view[DATA_MET_BIT]                 = data_met_ff;
        ctrl_view[ERR_THR_LSB +: THR_W]         = err_thr_ff;
        ctrl_view[DATA_THR_LSB +: THR_W]        = data_thr_ff;
    end

    always_comb begin
        rd_value = '0;
        unique case (idx_ff)
            CTRL_IDX:       rd_value[CTRL_W-1:0] = ctrl_view;
            IRQ_STATUS_IDX: rd_value[IRQ_W-1:0]  = irq_status_ff;
            IRQ_MASK_IDX:   rd_value[IRQ_W-1:0]  = irq_mask_ff;
            default:        rd_value = '0;
        endcase
    end

    // strap is sampled on the first edge after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_taken_ff <= 1'b0;
            enable_ff      <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            enable_ff      <= enable_strap;
        end else if (wr_apply && idx_ff == CTRL_IDX) begin
            enable_ff      <= hwdata[ENABLE_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_up_ff   <= AUTO_UP_RST;
            auto_down_ff <= AUTO_DOWN_RST;
            burst_dis_ff <= BURST_DIS_RST;
            err_thr_ff   <= THR_RST;
            data_thr_ff  <= THR_RST;
        end else if (wr_apply && idx_ff == CTRL_IDX) begin
            auto_up_ff   <= hwdata[AUTO_UP_BIT];
            auto_down_ff <= hwdata[AUTO_DOWN_BIT];
            burst_dis_ff <= hwdata[BURST_DIS_BIT];
            err_thr_ff   <= hwdata[ERR_THR_LSB +: THR_W];
            data_thr_ff  <= hwdata[DATA_THR_LSB +: THR_W];
        end
    end

    // self-clearing strobes: each lives for exactly one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            manual_ff     <= 1'b0;
            soft_reset_ff <= 1'b0;
        end else begin
            manual_ff     <= wr_apply && idx_ff == CTRL_IDX && hwdata[MANUAL_BIT];
            soft_reset_ff <= wr_apply && idx_ff == SOFT_CTRL_IDX && hwdata[SOFT_RESET_BIT];
        end
    end

    // met flags: the read value was taken at this edge, a new set still wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_met_ff  <= 1'b0;
            data_met_ff <= 1'b0;
        end else if (soft_reset_ff) begin
            err_met_ff  <= 1'b0;
            data_met_ff <= 1'b0;
        end else begin
            if (err_if.met_p) begin
                err_met_ff <= 1'b1;
            end else if (rd_apply && idx_ff == CTRL_IDX) begin
                err_met_ff <= 1'b0;
            end
            if (data_if.met_p) begin
                data_met_ff <= 1'b1;
            end else if (rd_apply && idx_ff == CTRL_IDX) begin
                data_met_ff <= 1'b0;
            end
        end
    end

    // event counters; the error side only reports, it never moves the sequencer
    assign err_if.event_p    = enable_ff && error_event;
    assign err_if.threshold  = err_thr_ff;
    assign err_if.clear      = idle_clear || soft_reset_ff || pwr_change;
    assign data_if.event_p   = enable_ff && data_event;
    assign data_if.threshold = data_thr_ff;
    assign data_if.clear     = idle_clear || soft_reset_ff || pwr_change;

    threshold_counter #(.THR_W(THR_W)) err_counter (
        .hclk    (hclk),
        .hresetn (hresetn),
        .thr     (err_if.counter)
    );

    threshold_counter #(.THR_W(THR_W)) data_counter (
        .hclk    (hclk),
        .hresetn (hresetn),
        .thr     (data_if.counter)
    );

    // quiet timer restarts on every data event
    // a data event in the expiry cycle restarts the quiet time instead of being lost
    assign idle_clear = (idle_ff == IDLE_W'(IDLE_LIMIT - 1)) && !data_event;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_ff <= '0;
        end else if (data_event || soft_reset_ff || idle_clear) begin
            idle_ff <= '0;
        end else begin
            idle_ff <= idle_ff + IDLE_W'(1);
        end
    end

    // power sequencer
    assign go_up   = enable_ff && (state_ff == SEQ_DOWN)
                     && ((auto_up_ff && data_if.reached) || manual_ff);
    assign go_down = enable_ff && (state_ff != SEQ_DOWN)
                     && ((auto_down_ff && !line_energy) || manual_ff);
    assign pwr_change = go_up || go_down;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff       <= SEQ_DOWN;
            pwr_state_ff   <= 1'b0;
            pulses_left_ff <= '0;
            gap_ff         <= '0;
            pulse_ff       <= 1'b0;
        end else if (soft_reset_ff || !enable_ff) begin
            state_ff       <= SEQ_DOWN;
            pwr_state_ff   <= 1'b0;
            pulses_left_ff <= '0;
            gap_ff         <= '0;
            pulse_ff       <= 1'b0;
        end else begin
            pulse_ff <= 1'b0;
            unique case (state_ff)
                SEQ_DOWN: begin
                    if (go_up) begin
                        state_ff     <= SEQ_BURST;
                        pwr_state_ff <= 1'b1;
                        gap_ff       <= '0;
                        if (burst_dis_ff) begin
                            pulses_left_ff <= PULSE_CNT_W'(SINGLE_PULSES);
                        end else begin
                            pulses_left_ff <= PULSE_CNT_W'(BURST_LEN);
                        end
                    end
                end
                SEQ_BURST: begin
                    if (go_down) begin
                        state_ff     <= SEQ_DOWN;
                        pwr_state_ff <= 1'b0;
                    end else if (gap_ff != '0) begin
                        gap_ff <= gap_ff - GAP_W'(1);
                    end else if (pulses_left_ff != '0) begin
                        pulse_ff       <= 1'b1;
                        pulses_left_ff <= pulses_left_ff - PULSE_CNT_W'(1);
                        gap_ff         <= GAP_W'(PULSE_GAP - 1);
                    end else begin
                        state_ff <= SEQ_UP;
                    end
                end
                SEQ_UP: begin
                    if (go_down) begin
                        state_ff     <= SEQ_DOWN;
                        pwr_state_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // interrupt status, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_ff <= '0;
            irq_mask_ff   <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (wr_apply && idx_ff == IRQ_STATUS_IDX && hwdata[i]) begin
                    irq_status_ff[i] <= 1'b0;
                end
            end
            if (data_if.met_p) begin
                irq_status_ff[IRQ_DATA_BIT] <= 1'b1;
            end
            if (err_if.met_p) begin
                irq_status_ff[IRQ_ERR_BIT] <= 1'b1;
            end
            if (pwr_change && !soft_reset_ff) begin
                irq_status_ff[IRQ_PWR_BIT] <= 1'b1;
            end
            if (wr_apply && idx_ff == IRQ_MASK_IDX) begin
                irq_mask_ff <= hwdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign hrdata         = hrdata_ff;
    assign hreadyout      = hreadyout_ff;
    assign hresp          = 1'b0;
    assign detect_powered = pwr_state_ff;
    assign detect_pulse   = pulse_ff;
    assign irq            = irq_ff;
endmodule

//--- verification/line_model.sv
// line side model: energy level and one-cycle data and error event pulses.
// assumes the bench calls its tasks from one process on hclk.
module line_model (
    input  wire logic hclk,
    output logic      line_energy,
    output logic      data_event,
    output logic      error_event
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        line_energy = 1'b1;
        data_event  = 1'b0;
        error_event = 1'b0;
    end
    // an idle cycle between events keeps each one a separate line event
    task automatic send(input logic err, input int n);
        repeat (n) begin
            @(posedge hclk);
            error_event <= err;
            data_event  <= !err;
            @(posedge hclk);
            error_event <= 1'b0;
            data_event  <= 1'b0;
        end
    endtask
    task automatic energy(input logic v);
        @(posedge hclk);
        line_energy <= v;
    endtask
endmodule

//--- verification/energy_detect_chk.sv
// port checker for energy_detect_power_control: bus timing, pulses, power causes.
// assumes one slave with hready tied to hreadyout.
module energy_detect_chk
    import energy_detect_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES,
    parameter int PULSE_GAP  = PULSE_GAP_CYCLES,
    parameter int BURST_LEN  = BURST_PULSES
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        line_energy,
    input wire logic        data_event,
    input wire logic        detect_powered,
    input wire logic        detect_pulse
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       take;
    logic [4:0] wr_hist_ff;
    logic [2:0] pcnt_ff;
    assign take = hsel & htrans[1] & hready;
    // manual toggle and soft reset land a few cycles after their write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_hist_ff <= 5'h0;
        else wr_hist_ff <= {wr_hist_ff[3:0], take & hwrite};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pcnt_ff <= 3'h0;
        else pcnt_ff <= detect_powered ? pcnt_ff + 3'(detect_pulse) : 3'h0;
    end
    sequence rd_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence up_s;
        $rose(detect_powered) ##1 detect_powered;
    endsequence
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    read_wait_a: assert property (take && !hwrite |=> rd_wait_s)
        else $error("read wait state wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");
    pulse_short_a: assert property (detect_pulse |=> !detect_pulse)
        else $error("pulse longer than one cycle");
    pulse_power_a: assert property (detect_pulse |-> $past(detect_powered))
        else $error("pulse while powered down");
    first_pulse_a: assert property (up_s |-> detect_pulse)
        else $error("no pulse after power up");
    burst_len_a: assert property (detect_pulse |-> pcnt_ff < BURST_LEN)
        else $error("too many pulses");
    rise_cause_a: assert property ($rose(detect_powered) |->
        $past(data_event, 2) || $past(data_event, 3) || |wr_hist_ff)
        else $error("power up without cause");
    fall_cause_a: assert property ($fell(detect_powered) |->
        !$past(line_energy) || !$past(line_energy, 2) || |wr_hist_ff)
        else $error("power down without cause");
endmodule

bind energy_detect_power_control energy_detect_chk #(.IDLE_LIMIT(IDLE_LIMIT),
    .PULSE_GAP(PULSE_GAP), .BURST_LEN(BURST_LEN)) energy_detect_chk_i (.hclk, .hresetn,
    .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .line_energy,
    .data_event, .detect_powered, .detect_pulse);

//--- verification/tb.sv
// self-checking bench for energy_detect_power_control over AHB-Lite.
// assumes one slave with hready tied to hreadyout and shortened counts.
module tb;
    import energy_detect_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE_SIM = 50;
    logic        hclk, hresetn, hsel, hwrite, hready, enable_strap;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rnd;
    logic        hreadyout, hresp, line_energy, data_event, error_event;
    logic        detect_powered, detect_pulse, irq;
    logic [15:0] cfg;
    int          miscompares, comparisons, pulses, p0;
    energy_detect_power_control #(.IDLE_LIMIT(IDLE_SIM), .PULSE_GAP(4),
        .BURST_LEN(BURST_PULSES)) energy_detect_power_control_i (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .enable_strap, .line_energy, .data_event, .error_event, .detect_powered,
        .detect_pulse, .irq);
    line_model line_model_i (.hclk, .line_energy, .data_event, .error_event);
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    always @(posedge hclk) if (detect_pulse === 1'b1) pulses++;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // manual bit reads back 0, status bits come from the block
    function automatic logic [31:0] ctrl_exp(input logic [15:0] c, input logic pw,
                                             input logic em, input logic dm);
        return {16'h0, c[15:13], 1'b0, c[11], pw, em, dm, c[7:0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // no cycle limit here: only the watchdog ends a stalled transfer
    task automatic wait_rdy();
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'b00};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        check(what, d, exp);
    endtask
    task automatic wait_pow(input logic v);
        int n;
        n = 0;
        while (detect_powered !== v && n < 40) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic print_verdict();
        $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        print_verdict();
    end
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        enable_strap = 1'b1;
        rnd = 32'h361018b4;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("ctrl reset", CTRL_IDX, ctrl_exp(16'he011, 0, 0, 0));
        rd_chk("mask reset", IRQ_MASK_IDX, 32'h0);
        rd_chk("unmapped", 8'h10, 32'h0);
        $display("test reset done");
        rnd = lfsr(rnd);
        cfg = {8'he0, 4'(rnd[1:0]) + 4'h2, 4'hf};
        // crossover and page select live outside this block
        wr(CTRL_IDX, {16'h0, cfg});
        line_model_i.send(1'b0, 1);
        line_model_i.send(1'b1, int'(cfg[7:4]) - 1);
        rd_chk("err below", CTRL_IDX, ctrl_exp(cfg, 0, 0, 0));
        line_model_i.send(1'b1, 1);
        rd_chk("err met", CTRL_IDX, ctrl_exp(cfg, 0, 1, 0));
        check("err no action", detect_powered, 0);
        rd_chk("err cleared", CTRL_IDX, ctrl_exp(cfg, 0, 0, 0));
        $display("test error threshold done");
        rnd = lfsr(rnd);
        cfg[3:0] = 4'(rnd[1:0]) + 4'h2;
        wr(CTRL_IDX, {16'h0, cfg});
        wr(IRQ_MASK_IDX, 32'h1);
        repeat (IDLE_SIM + 10) @(posedge hclk);
        line_model_i.send(1'b0, int'(cfg[3:0]) - 1);
        // a wrong early power-up only shows two edges after the last event
        repeat (3) @(posedge hclk);
        check("up early", detect_powered, 0);
        p0 = pulses;
        line_model_i.send(1'b0, 1);
        wait_pow(1'b1);
        check("auto up", detect_powered, 1);
        repeat (40) @(posedge hclk);
        check("burst", pulses - p0, BURST_PULSES);
        check("irq raised", irq, 1);
        rd_chk("data met", CTRL_IDX, ctrl_exp(cfg, 1, 0, 1));
        rd_chk("status", IRQ_STATUS_IDX, 32'h7);
        wr(IRQ_STATUS_IDX, 32'h1);
        repeat (2) @(posedge hclk);
        check("irq masked", irq, 0);
        wr(IRQ_STATUS_IDX, 32'h7);
        rd_chk("status clear", IRQ_STATUS_IDX, 32'h0);
        $display("test data threshold done");
        line_model_i.energy(1'b0);
        wait_pow(1'b0);
        check("auto down", detect_powered, 0);
        line_model_i.energy(1'b1);
        wr(IRQ_STATUS_IDX, 32'h7);
        p0 = pulses;
        wr(CTRL_IDX, {16'h0, cfg | 16'h1800});
        wait_pow(1'b1);
        check("manual up", detect_powered, 1);
        repeat (40) @(posedge hclk);
        check("single", pulses - p0, SINGLE_PULSES);
        rd_chk("ctrl manual", CTRL_IDX, ctrl_exp(cfg | 16'h0800, 1, 0, 0));
        wr(SOFT_CTRL_IDX, 32'h1 << SOFT_RESET_BIT);
        wait_pow(1'b0);
        check("soft reset", detect_powered, 0);
        rd_chk("ctrl kept", CTRL_IDX, ctrl_exp(cfg | 16'h0800, 0, 0, 0));
        $display("test power control done");
        wr(CTRL_IDX, {16'h0, cfg & 16'h7fff});
        line_model_i.send(1'b0, 6);
        check("disabled", detect_powered, 0);
        $display("test disable done");
        print_verdict();
    end
endmodule
